// ---- design/sckd_regs.sv ----
// sample clock delay and clock detect register group with axi4-lite access
`timescale 1ns/1ps
module sckd_regs
    import sckd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [sckd_pkg::ADDR_W-1:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [sckd_pkg::DATA_W-1:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [sckd_pkg::ADDR_W-1:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [sckd_pkg::DATA_W-1:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic clk_detected,
    output sckd_pkg::sckd_skew_t local_fine,
    output sckd_pkg::sckd_skew_t digital_fine,
    output sckd_pkg::sckd_skew_t digital_superfine,
    output logic fine_limited,
    output logic low_jitter,
    output logic [1:0] detect_threshold,
    output logic irq
);
    import sckd_pkg::*;

    sckd_wr_t wr;
    logic wr_ok;
    logic rd_en;
    logic [IDX_W-1:0] rd_idx;
    logic [7:0] rd_data;
    logic rd_ok;
    logic wr_lane0;
    logic [7:0] wbyte;
    // per-register write strobes and detect edges
    logic wr_mode;
    logic wr_local;
    logic wr_super;
    logic wr_fine;
    logic wr_det;
    logic wr_mask;
    logic wr_clr;
    logic clk_gained;
    logic clk_lost;

    logic [2:0] mode_q;
    logic [7:0] local_fine_q;
    logic [7:0] dig_super_q;
    logic [7:0] dig_fine_q;
    logic [1:0] det_thr_q;
    logic [2:0] det_rsvd_q;
    logic [NUM_EV-1:0] irq_mask_q;
    logic clk_det_q;

    logic [NUM_EV-1:0] ev;
    logic [NUM_EV-1:0] ev_clr;
    logic [NUM_EV-1:0] ev_sts;

    logic fine_en;
    logic super_en;
    logic lim_en;
    logic lj_en;
    logic mode_bad;
    logic [7:0] apply_sts;

    sckd_skew_t local_fine_d;
    sckd_skew_t local_fine_q2;
    sckd_skew_t dig_fine_d;
    sckd_skew_t dig_fine_q2;
    sckd_skew_t dig_super_d;
    sckd_skew_t dig_super_q2;
    logic lim_q;
    logic lj_q;

    sckd_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axil_awaddr(s_axil_awaddr),
        .s_axil_awvalid(s_axil_awvalid),
        .s_axil_awready(s_axil_awready),
        .s_axil_wdata(s_axil_wdata),
        .s_axil_wstrb(s_axil_wstrb),
        .s_axil_wvalid(s_axil_wvalid),
        .s_axil_wready(s_axil_wready),
        .s_axil_bresp(s_axil_bresp),
        .s_axil_bvalid(s_axil_bvalid),
        .s_axil_bready(s_axil_bready),
        .s_axil_araddr(s_axil_araddr),
        .s_axil_arvalid(s_axil_arvalid),
        .s_axil_arready(s_axil_arready),
        .s_axil_rdata(s_axil_rdata),
        .s_axil_rresp(s_axil_rresp),
        .s_axil_rvalid(s_axil_rvalid),
        .s_axil_rready(s_axil_rready),
        .wr(wr),
        .wr_ok(wr_ok),
        .rd_en(rd_en),
        .rd_idx(rd_idx),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // registers are one byte wide, so only lane 0 carries data
    assign wr_lane0 = wr.en && wr.strb[0];
    assign wbyte = wr.data[7:0];

    // one decode per register; every writer below keys on these alone
    assign wr_mode = wr_lane0 && (wr.idx == IDX_DELAY_MODE);
    assign wr_local = wr_lane0 && (wr.idx == IDX_LOCAL_FINE);
    assign wr_super = wr_lane0 && (wr.idx == IDX_DIG_SUPER);
    assign wr_fine = wr_lane0 && (wr.idx == IDX_DIG_FINE);
    assign wr_det = wr_lane0 && (wr.idx == IDX_DET_CTRL);
    assign wr_mask = wr_lane0 && (wr.idx == IDX_IRQ_MASK);
    assign wr_clr = wr_lane0 && (wr.idx == IDX_IRQ_STS);

    // write decode; the read-only clock and apply status registers answer okay and ignore data
    always_comb begin
        unique case (wr.idx)
            IDX_DELAY_MODE,
            IDX_LOCAL_FINE,
            IDX_DIG_SUPER,
            IDX_DIG_FINE,
            IDX_DET_CTRL,
            IDX_CLK_STS,
            IDX_IRQ_STS,
            IDX_IRQ_MASK,
            IDX_APPLY_STS: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= RST_DELAY_MODE;
        end else if (wr_mode) begin
            mode_q <= wbyte[2:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            local_fine_q <= RST_LOCAL_FINE;
        end else if (wr_local) begin
            local_fine_q <= wbyte;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dig_super_q <= RST_DIG_SUPER;
        end else if (wr_super) begin
            dig_super_q <= wbyte;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dig_fine_q <= RST_DIG_FINE;
        end else if (wr_fine) begin
            dig_fine_q <= wbyte;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            det_thr_q <= RST_DET_THR;
            det_rsvd_q <= RST_DET_RSVD;
        end else if (wr_det) begin
            det_thr_q <= wbyte[DET_THR_MSB:DET_THR_LSB];
            det_rsvd_q <= wbyte[DET_RSVD_MSB:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_q <= RST_IRQ_MASK;
        end else if (wr_mask) begin
            irq_mask_q <= wbyte[NUM_EV-1:0];
        end
    end

    // detect input is synchronous to aclk; registered for the status bit and edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_det_q <= 1'b0;
        end else begin
            clk_det_q <= clk_detected;
        end
    end

    // edges against the registered copy, which resets low, so a steady high input gives one gained event after reset
    assign clk_gained = clk_detected && !clk_det_q;
    assign clk_lost = !clk_detected && clk_det_q;

    // out-of-range codes are stored as written and only flagged
    always_comb begin
        ev = '0;
        ev[EV_CLK_GAINED] = clk_gained;
        ev[EV_CLK_LOST] = clk_lost;
        if (wr_lane0) begin
            if ((wr.idx == IDX_LOCAL_FINE || wr.idx == IDX_DIG_FINE)
                    && wbyte > FINE_MAX_STEPS) begin
                ev[EV_RANGE] = 1'b1;
            end
            if (wr.idx == IDX_DIG_SUPER && wbyte > SUPER_MAX_STEPS) begin
                ev[EV_RANGE] = 1'b1;
            end
        end
    end

    // a clearing write never beats an event landing on the same edge
    assign ev_clr = wr_clr ? wbyte[NUM_EV-1:0] : '0;

    sckd_events u_events (
        .aclk(aclk),
        .aresetn(aresetn),
        .ev(ev),
        .clr(ev_clr),
        .mask(irq_mask_q),
        .sts(ev_sts),
        .irq(irq)
    );

    // mode decode; the unlisted codes 001, 101 and 111 apply no delay
    always_comb begin
        fine_en = 1'b0;
        super_en = 1'b0;
        lim_en = 1'b0;
        lj_en = 1'b0;
        mode_bad = 1'b0;
        unique case (mode_q)
            MODE_NONE: begin
                fine_en = 1'b0;
            end
            // superfine rides along here too, though this mode limits fine steps
            MODE_FINE_LIM: begin
                fine_en = 1'b1;
                super_en = 1'b1;
                lim_en = 1'b1;
            end
            MODE_FINE_LIM_LJ: begin
                fine_en = 1'b1;
                lim_en = 1'b1;
                lj_en = 1'b1;
            end
            MODE_FINE_FULL: begin
                fine_en = 1'b1;
            end
            MODE_FINE_SUPER: begin
                fine_en = 1'b1;
                super_en = 1'b1;
            end
            default: begin
                mode_bad = 1'b1;
            end
        endcase
    end

    // gated copies only; stored codes are untouched, so reenabling restores them
    always_comb begin
        local_fine_d.en = fine_en;
        local_fine_d.steps = '0;
        dig_fine_d.en = fine_en;
        dig_fine_d.steps = '0;
        dig_super_d.en = super_en;
        dig_super_d.steps = super_en ? dig_super_q : 8'h00;
        if (fine_en) begin
            local_fine_d.steps = local_fine_q;
            dig_fine_d.steps = dig_fine_q;
            if (lim_en && local_fine_q > FINE_LIMITED_MAX) begin
                local_fine_d.steps = FINE_LIMITED_MAX;
            end
            if (lim_en && dig_fine_q > FINE_LIMITED_MAX) begin
                dig_fine_d.steps = FINE_LIMITED_MAX;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            local_fine_q2 <= '0;
            dig_fine_q2 <= '0;
            dig_super_q2 <= '0;
            lim_q <= 1'b0;
            lj_q <= 1'b0;
        end else begin
            local_fine_q2 <= local_fine_d;
            dig_fine_q2 <= dig_fine_d;
            dig_super_q2 <= dig_super_d;
            lim_q <= lim_en;
            lj_q <= lj_en;
        end
    end

    assign local_fine = local_fine_q2;
    assign digital_fine = dig_fine_q2;
    assign digital_superfine = dig_super_q2;
    assign fine_limited = lim_q;
    assign low_jitter = lj_q;
    assign detect_threshold = det_thr_q;

    always_comb begin
        apply_sts = '0;
        apply_sts[AP_FINE] = fine_en;
        apply_sts[AP_SUPER] = super_en;
        apply_sts[AP_LIMITED] = lim_en;
        apply_sts[AP_LOWJIT] = lj_en;
        apply_sts[AP_ILLEGAL] = mode_bad;
    end

    // read mux; unused high bits read as zero
    always_comb begin
        rd_data = '0;
        rd_ok = 1'b1;
        unique case (rd_idx)
            IDX_DELAY_MODE: rd_data[2:0] = mode_q;
            IDX_LOCAL_FINE: rd_data = local_fine_q;
            IDX_DIG_SUPER: rd_data = dig_super_q;
            IDX_DIG_FINE: rd_data = dig_fine_q;
            IDX_DET_CTRL: begin
                rd_data[DET_THR_MSB:DET_THR_LSB] = det_thr_q;
                rd_data[DET_RSVD_MSB:0] = det_rsvd_q;
            end
            IDX_CLK_STS: rd_data[0] = clk_det_q;
            IDX_IRQ_STS: rd_data[NUM_EV-1:0] = ev_sts;
            IDX_IRQ_MASK: rd_data[NUM_EV-1:0] = irq_mask_q;
            IDX_APPLY_STS: rd_data = apply_sts;
            default: rd_ok = 1'b0;
        endcase
    end

endmodule : sckd_regs

// ---- design/sckd_pkg.sv ----
// constants, types and register map of the sample clock delay and detect register group
// Function
// - Local fine skew: 8-bit unsigned, 1.725 ps per count, resets to 0xC0.
// - Local fine skew acts only in delay modes 0x2, 0x3, 0x4, 0x6.
// - Digital super-fine delay: 8-bit unsigned, 0.25 ps steps, resets to zero.
// - Super-fine delay acts only in delay modes 010 and 110.
// - Digital fine skew: 8-bit, 1.725 ps steps, reset 0xC0, modes 2,3,4,6.
// - Detection threshold field resets to 01; software picks it by sample rate.
// - Read-only bit 0 shows input clock detected and locked.
// - Mode decode: none, fine limited to 16, limited with low jitter, fine full, fine plus super-fine.
package sckd_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W = 10;
    localparam int NUM_EV = 3;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_DELAY_MODE = 10'h110;
    localparam logic [IDX_W-1:0] IDX_LOCAL_FINE = 10'h112;
    localparam logic [IDX_W-1:0] IDX_DIG_SUPER = 10'h113;
    localparam logic [IDX_W-1:0] IDX_DIG_FINE = 10'h114;
    localparam logic [IDX_W-1:0] IDX_DET_CTRL = 10'h11a;
    localparam logic [IDX_W-1:0] IDX_CLK_STS = 10'h11b;
    localparam logic [IDX_W-1:0] IDX_IRQ_STS = 10'h130;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h131;
    localparam logic [IDX_W-1:0] IDX_APPLY_STS = 10'h132;

    // reset values
    localparam logic [2:0] RST_DELAY_MODE = 3'h0;
    localparam logic [7:0] RST_LOCAL_FINE = 8'hc0;
    localparam logic [7:0] RST_DIG_SUPER = 8'h00;
    localparam logic [7:0] RST_DIG_FINE = 8'hc0;
    localparam logic [1:0] RST_DET_THR = 2'h1;
    localparam logic [2:0] RST_DET_RSVD = 3'h6;
    localparam logic [NUM_EV-1:0] RST_IRQ_MASK = 3'h0;

    // field positions of the detection control register
    localparam int DET_THR_LSB = 3;
    localparam int DET_THR_MSB = 4;
    localparam int DET_RSVD_MSB = 2;

    // step limits
    localparam logic [7:0] FINE_MAX_STEPS = 8'hc0;
    localparam logic [7:0] FINE_LIMITED_MAX = 8'h10;
    localparam logic [7:0] SUPER_MAX_STEPS = 8'h80;

    // event bits
    localparam int EV_CLK_GAINED = 0;
    localparam int EV_CLK_LOST = 1;
    localparam int EV_RANGE = 2;

    // apply status bits
    localparam int AP_FINE = 0;
    localparam int AP_SUPER = 1;
    localparam int AP_LIMITED = 2;
    localparam int AP_LOWJIT = 3;
    localparam int AP_ILLEGAL = 4;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        MODE_NONE = 3'b000,
        MODE_FINE_LIM = 3'b010,
        MODE_FINE_LIM_LJ = 3'b011,
        MODE_FINE_FULL = 3'b100,
        MODE_FINE_SUPER = 3'b110
    } sckd_mode_t;

    typedef struct packed {
        logic en;
        logic [7:0] steps;
    } sckd_skew_t;

    typedef struct packed {
        logic en;
        logic [IDX_W-1:0] idx;
        logic [DATA_W-1:0] data;
        logic [3:0] strb;
    } sckd_wr_t;

endpackage : sckd_pkg

// ---- design/sckd_axil.sv ----
// axi4-lite slave front end: address capture, response and read data registers
`timescale 1ns/1ps
module sckd_axil
    import sckd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [sckd_pkg::ADDR_W-1:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [sckd_pkg::DATA_W-1:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [sckd_pkg::ADDR_W-1:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [sckd_pkg::DATA_W-1:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    output sckd_pkg::sckd_wr_t wr,
    input wire logic wr_ok,
    output logic rd_en,
    output logic [sckd_pkg::IDX_W-1:0] rd_idx,
    input wire logic [7:0] rd_data,
    input wire logic rd_ok
);
    import sckd_pkg::*;

    logic aw_held_q;
    logic w_held_q;
    logic [IDX_W-1:0] awidx_q;
    logic [DATA_W-1:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;

    // channels are held until the response is gone, so one write is in flight
    assign s_axil_awready = !aw_held_q && !bvalid_q;
    assign s_axil_wready = !w_held_q && !bvalid_q;
    assign wr.en = aw_held_q && w_held_q && !bvalid_q;
    assign wr.idx = awidx_q;
    assign wr.data = wdata_q;
    assign wr.strb = wstrb_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awidx_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (wr.en) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
        end else begin
            if (s_axil_awvalid && s_axil_awready) begin
                aw_held_q <= 1'b1;
                awidx_q <= s_axil_awaddr[ADDR_W-1:2];
            end
            if (s_axil_wvalid && s_axil_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axil_wdata;
                wstrb_q <= s_axil_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr.en) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axil_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axil_bvalid = bvalid_q;
    assign s_axil_bresp = bresp_q;

    assign s_axil_arready = !rvalid_q;
    assign rd_en = s_axil_arvalid && !rvalid_q;
    assign rd_idx = s_axil_araddr[ADDR_W-1:2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (rd_en) begin
            rvalid_q <= 1'b1;
            rdata_q <= {{(DATA_W-8){1'b0}}, rd_data};
            rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axil_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axil_rvalid = rvalid_q;
    assign s_axil_rdata = rdata_q;
    assign s_axil_rresp = rresp_q;

endmodule : sckd_axil

// ---- design/sckd_events.sv ----
// sticky event status bits with write-one-to-clear and masked interrupt
`timescale 1ns/1ps
module sckd_events
    import sckd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [sckd_pkg::NUM_EV-1:0] ev,
    input wire logic [sckd_pkg::NUM_EV-1:0] clr,
    input wire logic [sckd_pkg::NUM_EV-1:0] mask,
    output logic [sckd_pkg::NUM_EV-1:0] sts,
    output logic irq
);
    import sckd_pkg::*;

    logic [NUM_EV-1:0] sts_q;

    for (genvar i = 0; i < NUM_EV; i++) begin : g_ev
        // a new event in the clearing cycle keeps the bit set
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                sts_q[i] <= 1'b0;
            end else if (ev[i]) begin
                sts_q[i] <= 1'b1;
            end else if (clr[i]) begin
                sts_q[i] <= 1'b0;
            end
        end
    end

    assign sts = sts_q;
    assign irq = |(sts_q & mask);

endmodule : sckd_events

// ---- tb/sckd_regs_monitor.sv ----
// concurrent checks on the delay outputs and bus answers of the register group
`timescale 1ns/1ps
module sckd_regs_monitor
    import sckd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axil_awvalid,
    input wire logic s_axil_awready,
    input wire logic s_axil_wvalid,
    input wire logic s_axil_wready,
    input wire logic s_axil_bvalid,
    input wire logic s_axil_arvalid,
    input wire logic s_axil_arready,
    input wire logic [sckd_pkg::DATA_W-1:0] s_axil_rdata,
    input wire logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire sckd_pkg::sckd_skew_t local_fine,
    input wire sckd_pkg::sckd_skew_t digital_fine,
    input wire sckd_pkg::sckd_skew_t digital_superfine,
    input wire logic fine_limited,
    input wire logic low_jitter,
    input wire logic [1:0] detect_threshold
);
    import sckd_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rst_out;
        $rose(aresetn) |-> detect_threshold == 2'h1 && !local_fine.en && !digital_superfine.en;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs not at reset state");
    property p_fine_pair;
        local_fine.en == digital_fine.en;
    endproperty
    a_fine_pair: assert property (p_fine_pair) else $error("fine enables differ");
    property p_fine_off;
        !local_fine.en |-> local_fine.steps == 8'h0 && !digital_superfine.en;
    endproperty
    a_fine_off: assert property (p_fine_off) else $error("disabled fine skew drives steps");
    property p_super_on;
        digital_superfine.en |-> local_fine.en && !low_jitter;
    endproperty
    a_super_on: assert property (p_super_on) else $error("superfine on in wrong mode");
    property p_clamp;
        fine_limited |-> local_fine.steps <= 8'h10 && digital_fine.steps <= 8'h10;
    endproperty
    a_clamp: assert property (p_clamp) else $error("limited mode exceeds 16 steps");
    property p_lowjit;
        low_jitter |-> fine_limited && local_fine.en;
    endproperty
    a_lowjit: assert property (p_lowjit) else $error("low jitter outside limited mode");
    property p_wr_ans;
        s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready |=> ##1 s_axil_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
    property p_rd_ans;
        s_axil_arvalid && s_axil_arready |=> s_axil_rvalid;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    property p_rd_hold;
        s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data dropped early");
    property p_rd_pad;
        s_axil_rvalid |-> s_axil_rdata[31:8] == 24'h0000_00;
    endproperty
    a_rd_pad: assert property (p_rd_pad) else $error("read data upper bits set");
endmodule : sckd_regs_monitor

bind sckd_regs sckd_regs_monitor i_sckd_regs_monitor (
    .aclk(aclk), .aresetn(aresetn), .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready), .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready), .s_axil_bvalid(s_axil_bvalid),
    .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata), .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready),
    .local_fine(local_fine), .digital_fine(digital_fine),
    .digital_superfine(digital_superfine), .fine_limited(fine_limited),
    .low_jitter(low_jitter), .detect_threshold(detect_threshold)
);

// ---- tb/sckd_regs_tb_top.sv ----
// self-checking bench for the clock delay register group over axi4-lite
`timescale 1ns/1ps
module sckd_regs_tb_top;
    import sckd_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic clk_det = 1'b0;
    logic [DATA_W-1:0] wdata = '0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, lim, lj, irq;
    logic [1:0] bresp, rresp, thr;
    sckd_skew_t lf, df, sf;
    int err_total = 0, comparisons = 0, seed = 53;
    logic [1:0] bq[$];
    logic [33:0] rq[$];

    always #2 aclk = ~aclk;

    sckd_regs i_sckd_regs (
        .aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
        .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(wstrb),
        .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
        .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
        .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
        .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
        .clk_detected(clk_det), .local_fine(lf), .digital_fine(df), .digital_superfine(sf),
        .fine_limited(lim), .low_jitter(lj), .detect_threshold(thr), .irq(irq)
    );

    task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // upper data bits are random: only byte lane 0 may land
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d, input logic [1:0] er);
        bq.push_back(er);
        awaddr <= {idx, 2'h0};
        wdata <= {24'($random(seed)), d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        // raised once both channels are gone, so back-to-back calls never re-raise it
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
    endtask : wr

    // random stall before rready exercises the hold of read data
    task automatic rd(input logic [IDX_W-1:0] idx, input logic [33:0] e);
        rq.push_back(e);
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        repeat ($unsigned($random(seed)) % 3) @(posedge aclk);
        rready <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
    endtask : rd

    always @(posedge aclk) begin
        if (bvalid && bready) check("bresp", 34'(bresp), 34'(bq.pop_front()));
        if (rvalid && rready) check("rdata", {rresp, rdata}, rq.pop_front());
    end

    initial begin
        #80000;
        err_total++;
        print_verdict();
    end

    initial begin
        int m;
        logic fo, so, li;
        logic [7:0] lfv, dfv, sfv;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("thr", 34'(thr), 34'h1);
        rd(IDX_DELAY_MODE, 34'h0);
        rd(IDX_LOCAL_FINE, 34'hc0);
        rd(IDX_DIG_SUPER, 34'h0);
        rd(IDX_DIG_FINE, 34'hc0);
        rd(IDX_DET_CTRL, 34'he);
        rd(IDX_CLK_STS, 34'h0);
        rd(IDX_IRQ_MASK, 34'h0);
        rd(10'h111, {RESP_SLVERR, 32'h0});
        wr(10'h100, 8'h55, RESP_SLVERR);
        wr(IDX_CLK_STS, 8'h01, RESP_OKAY);
        rd(IDX_CLK_STS, 34'h0);
        lfv = 8'h11 + 8'($unsigned($random(seed)) % 176);
        dfv = 8'($unsigned($random(seed)) % 193);
        sfv = 8'($unsigned($random(seed)) % 129);
        wr(IDX_LOCAL_FINE, lfv, RESP_OKAY);
        wr(IDX_DIG_FINE, dfv, RESP_OKAY);
        wr(IDX_DIG_SUPER, sfv, RESP_OKAY);
        rd(IDX_DIG_SUPER, 34'(sfv));
        // modes 2 and 6 follow disabled modes, so stored codes must survive
        for (m = 0; m < 8; m++) begin
            wr(IDX_DELAY_MODE, 8'(m), RESP_OKAY);
            repeat (2) @(posedge aclk);
            fo = m inside {2, 3, 4, 6};
            so = m inside {2, 6};
            li = m inside {2, 3};
            check("lf", 34'(lf), {25'h0, fo, fo ? (li && lfv > 8'h10 ? 8'h10 : lfv) : 8'h0});
            check("df", 34'(df), {25'h0, fo, fo ? (li && dfv > 8'h10 ? 8'h10 : dfv) : 8'h0});
            check("sf", 34'(sf), {25'h0, so, so ? sfv : 8'h0});
            check("lim", 34'({lim, lj}), 34'({li, m == 3}));
            rd(IDX_APPLY_STS, 34'({m inside {1, 5, 7}, m == 3, li, so, fo}));
        end
        wr(IDX_DET_CTRL, 8'hf6, RESP_OKAY);
        rd(IDX_DET_CTRL, 34'h16);
        check("thr", 34'(thr), 34'h2);
        clk_det <= 1'b1;
        repeat (3) @(posedge aclk);
        rd(IDX_CLK_STS, 34'h1);
        rd(IDX_IRQ_STS, 34'h1);
        check("irq", 34'(irq), 34'h0);
        wr(IDX_IRQ_MASK, 8'h07, RESP_OKAY);
        @(posedge aclk);
        check("irq", 34'(irq), 34'h1);
        wr(IDX_IRQ_STS, 8'h01, RESP_OKAY);
        @(posedge aclk);
        check("irq", 34'(irq), 34'h0);
        clk_det <= 1'b0;
        repeat (3) @(posedge aclk);
        check("irq", 34'(irq), 34'h1);
        wr(IDX_LOCAL_FINE, 8'hc1, RESP_OKAY);
        rd(IDX_IRQ_STS, 34'h6);
        wr(IDX_IRQ_MASK, 8'h01, RESP_OKAY);
        @(posedge aclk);
        check("irq", 34'(irq), 34'h0);
        wr(IDX_IRQ_STS, 8'h06, RESP_OKAY);
        rd(IDX_IRQ_STS, 34'h0);
        // mid-run reset must drop the applied delays and return stored codes to their reset values
        wr(IDX_DELAY_MODE, 8'h06, RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("lf", 34'(lf), 34'h1c1);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("lf", 34'(lf), 34'h0);
        rd(IDX_LOCAL_FINE, 34'hc0);
        rd(IDX_DELAY_MODE, 34'h0);
        print_verdict();
    end
endmodule : sckd_regs_tb_top
